// *** core/masel_top.v ***
// map address decode and sub map select for the i2c register space
// assumes an i2c slave front end that presents the address byte of each
// transfer and register writes already decoded, all on i_sys_clk
`timescale 1ns/100ps
`default_nettype none
`include "masel_regs.vh"
module masel_top (
   input  wire       i_sys_clk,
   input  wire       i_rst_b,
   input  wire       i_address_strap_input,
   input  wire       i_addr_valid,
   input  wire [7:0] i_addr_byte,
   input  wire       i_reg_we,
   input  wire [7:0] i_reg_addr,
   input  wire [7:0] i_reg_wdata,
   input  wire       i_reg_re,
   output wire       o_addr_ack,
   output wire       o_hit_main,
   output wire       o_hit_out_map,
   output wire       o_read_xfer,
   output wire [1:0] o_submap_select,
   output wire       o_sel_user,
   output wire       o_sel_intr_vbi,
   output wire       o_sel_user2,
   output wire [7:0] o_reg_rdata,
   output wire       o_reg_hit
);
   ////////////////////////////////////////////////////////////////////////
   // sub maps behind the main address; code 11 is left without one
   localparam NUM_SUBMAP = 3;

   ////////////////////////////////////////////////////////////////////////
   // strap synchroniser: second stage alone feeds the decode
   reg        strap_meta_ff;
   reg        strap_ff;
   always @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         strap_meta_ff <= 1'b0;
         strap_ff      <= 1'b0;
      end else begin
         strap_meta_ff <= i_address_strap_input;
         strap_ff      <= strap_meta_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register write decode; 0xfe lives only in the user sub map
   wire [7:0] submap_select_control;
   wire [7:0] output_map_slave_address;
   wire [1:0] select_field;
   wire       user_map;
   wire       hit_sel_reg;
   wire       hit_oma_reg;
   wire       we_sel;
   wire       we_oma;
   assign select_field = submap_select_control[`MASEL_SEL_MSB:`MASEL_SEL_LSB];
   assign user_map     = (select_field == `MASEL_SEL_USER);
   // the select register answers in every sub map so the host can always return
   assign hit_sel_reg  = (i_reg_addr == `MASEL_OFS_SUBMAP_SELECT);
   assign hit_oma_reg  = user_map && (i_reg_addr == `MASEL_OFS_OUT_MAP_ADDR);
   assign we_sel       = i_reg_we && hit_sel_reg;
   assign we_oma       = i_reg_we && hit_oma_reg;

   ////////////////////////////////////////////////////////////////////////
   // the two register cells; bits outside the used fields read back as written
   masel_reg8 #(
      .RST_VAL (`MASEL_RST_SUBMAP_SELECT)
   ) u_sel (
      .i_sys_clk (i_sys_clk),
      .i_rst_b   (i_rst_b),
      .i_we      (we_sel),
      .i_wdata   (i_reg_wdata),
      .o_q       (submap_select_control)
   );

   // a zero reset value keeps the output map deaf until the host programs it
   masel_reg8 #(
      .RST_VAL (`MASEL_RST_OUT_MAP_ADDR)
   ) u_oma (
      .i_sys_clk (i_sys_clk),
      .i_rst_b   (i_rst_b),
      .i_we      (we_oma),
      .i_wdata   (i_reg_wdata),
      .o_q       (output_map_slave_address)
   );

   ////////////////////////////////////////////////////////////////////////
   // address byte decode
   wire [6:0] addr_seven;
   wire       addr_rw_bit;
   wire [6:0] out_addr;
   wire       out_enabled;
   wire       hit_main;
   wire       hit_out;
   reg  [6:0] main_addr;
   assign addr_seven  = i_addr_byte[7:1];
   assign addr_rw_bit = i_addr_byte[0];
   // the strap is a board level: a change in mid transfer is not guarded against
   always @* begin
      if (strap_ff) begin
         main_addr = `MASEL_MAIN_ADDR_STRAP_HI;
      end else begin
         main_addr = `MASEL_MAIN_ADDR_STRAP_LO;
      end
   end
   assign out_addr    = output_map_slave_address[`MASEL_ADDR_MSB:`MASEL_ADDR_LSB];
   // a zero address means never programmed: the map stays deaf
   assign out_enabled = (out_addr != 7'h00);
   assign hit_main    = (addr_seven == main_addr);
   assign hit_out     = out_enabled && (addr_seven == out_addr);

   ////////////////////////////////////////////////////////////////////////
   // address answer: each flag follows i_addr_valid one cycle later, for as long as it stands
   reg        addr_ack_ff;
   reg        hit_main_ff;
   reg        hit_out_map_ff;
   reg        read_xfer_ff;
   reg        nxt_addr_ack;
   reg        nxt_hit_main;
   reg        nxt_hit_out_map;
   reg        nxt_read_xfer;
   always @* begin
      nxt_addr_ack    = i_addr_valid && (hit_main || hit_out);
      nxt_hit_main    = i_addr_valid && hit_main;
      nxt_hit_out_map = i_addr_valid && hit_out;
      // the direction bit is passed on for any address; the front end gates it by ack
      nxt_read_xfer   = i_addr_valid && addr_rw_bit;
   end

   always @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         addr_ack_ff    <= 1'b0;
         hit_main_ff    <= 1'b0;
         hit_out_map_ff <= 1'b0;
         read_xfer_ff   <= 1'b0;
      end else begin
         addr_ack_ff    <= nxt_addr_ack;
         hit_main_ff    <= nxt_hit_main;
         hit_out_map_ff <= nxt_hit_out_map;
         read_xfer_ff   <= nxt_read_xfer;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sub map steering, one flag per sub map; bit n lights for select code n
   wire [NUM_SUBMAP-1:0] nxt_submap_onehot;
   reg  [NUM_SUBMAP-1:0] submap_onehot_ff;
   reg  [1:0]            submap_select_ff;
   reg  [1:0]            nxt_submap_select;
   genvar                gi;
   generate
      for (gi = 0; gi < NUM_SUBMAP; gi = gi + 1) begin : g_submap
         assign nxt_submap_onehot[gi] = ({30'h0, select_field} == gi);
      end
   endgenerate
   // steering lags the register by one cycle; a write counts from the next access on
   always @* begin
      nxt_submap_select = select_field;
   end
   always @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         submap_select_ff <= `MASEL_SEL_USER;
         submap_onehot_ff <= `MASEL_RST_SUBMAP_ONEHOT;
      end else begin
         submap_select_ff <= nxt_submap_select;
         submap_onehot_ff <= nxt_submap_onehot;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read back, one cycle after the read strobe; data holds until the next read
   reg  [7:0] reg_rdata_ff;
   reg        reg_hit_ff;
   reg  [7:0] nxt_reg_rdata;
   reg        nxt_reg_hit;
   always @* begin
      nxt_reg_rdata = reg_rdata_ff;
      nxt_reg_hit   = 1'b0;
      if (i_reg_re) begin
         case (i_reg_addr)
            `MASEL_OFS_SUBMAP_SELECT: begin
               nxt_reg_rdata = submap_select_control;
               nxt_reg_hit   = 1'b1;
            end
            `MASEL_OFS_OUT_MAP_ADDR: begin
               // hidden while another sub map is selected
               nxt_reg_rdata = user_map ? output_map_slave_address : 8'h00;
               nxt_reg_hit   = user_map;
            end
            default: begin
               // unmapped subaddress: zero, no hit
               nxt_reg_rdata = 8'h00;
            end
         endcase
      end
   end

   always @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         reg_rdata_ff <= `MASEL_RST_RDATA;
         reg_hit_ff   <= 1'b0;
      end else begin
         reg_rdata_ff <= nxt_reg_rdata;
         reg_hit_ff   <= nxt_reg_hit;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // address answer outputs, straight from flip-flops
   assign o_addr_ack      = addr_ack_ff;
   assign o_hit_main      = hit_main_ff;
   assign o_hit_out_map   = hit_out_map_ff;
   assign o_read_xfer     = read_xfer_ff;

   ////////////////////////////////////////////////////////////////////////
   // steering and read back outputs, straight from flip-flops
   assign o_submap_select = submap_select_ff;
   assign o_sel_user      = submap_onehot_ff[`MASEL_SEL_USER];
   assign o_sel_intr_vbi  = submap_onehot_ff[`MASEL_SEL_INTR_VBI];
   assign o_sel_user2     = submap_onehot_ff[`MASEL_SEL_USER2];
   assign o_reg_rdata     = reg_rdata_ff;
   assign o_reg_hit       = reg_hit_ff;
endmodule
`default_nettype wire

// *** core/masel_regs.vh ***
// constants of the map address and sub map select block
// assumes the block sits behind the i2c slave decode of the device
// How it works
// - output map 7-bit slave address is bits 7..1 of user register 0xfe.
// - that address register resets to 0x00; map stays silent until written.
// - output map answers both reads and writes at programmed address.
// - after reset main address accesses go to the user sub map.
// - bits 6..5 of register 0x0e pick the sub map at the main address.
// - select codes: 00 user, 01 interrupt/vbi data, 10 second user map.
// - main address 0x40 with strap low, 0x42 strap high; reads odd.
`ifndef MASEL_REGS_VH
`define MASEL_REGS_VH
`define MASEL_OFS_SUBMAP_SELECT   8'h0e
`define MASEL_OFS_OUT_MAP_ADDR    8'hfe
`define MASEL_SEL_LSB             5
`define MASEL_SEL_MSB             6
`define MASEL_ADDR_LSB            1
`define MASEL_ADDR_MSB            7
`define MASEL_RST_SUBMAP_SELECT   8'h00
`define MASEL_RST_OUT_MAP_ADDR    8'h00
`define MASEL_RST_SUBMAP_ONEHOT   3'h1
`define MASEL_RST_RDATA           8'h00
`define MASEL_SEL_USER            2'h0
`define MASEL_SEL_INTR_VBI        2'h1
`define MASEL_SEL_USER2           2'h2
`define MASEL_MAIN_ADDR_STRAP_LO  7'h20
`define MASEL_MAIN_ADDR_STRAP_HI  7'h21
`endif

// *** core/masel_reg8.v ***
// one 8-bit register with write strobe and async reset value
// assumes write strobe and data are on the system clock
`timescale 1ns/100ps
`default_nettype none
module masel_reg8 #(
   parameter [7:0] RST_VAL = 8'h00
) (
   input  wire       i_sys_clk,
   input  wire       i_rst_b,
   input  wire       i_we,
   input  wire [7:0] i_wdata,
   output wire [7:0] o_q
);
   reg [7:0] q_ff;
   always @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         q_ff <= RST_VAL;
      end else if (i_we) begin
         q_ff <= i_wdata;
      end
   end
   assign o_q = q_ff;
endmodule
`default_nettype wire

// *** testbench/masel_chk_asserts.sv ***
// checker for masel_top, port relations only
// assumes the bind below and one clock domain
`timescale 1ns/100ps
`default_nettype none
module masel_chk (
   input wire logic       i_sys_clk,
   input wire logic       i_rst_b,
   input wire logic       i_addr_valid,
   input wire logic [7:0] i_addr_byte,
   input wire logic       i_reg_we,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic       o_addr_ack,
   input wire logic       o_hit_main,
   input wire logic       o_hit_out_map,
   input wire logic       o_read_xfer,
   input wire logic [1:0] o_submap_select,
   input wire logic       o_sel_user
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_b);
   sequence s_wsel; i_reg_we && i_reg_addr == 8'h0e; endsequence
   property p_sel; s_wsel |=> ##1 o_submap_select == $past(i_reg_wdata[6:5], 2); endproperty
   a_sel: assert property (p_sel) else $error("select not applied");
   property p_usr; o_submap_select == 2'h0 |-> o_sel_user; endproperty
   a_usr: assert property (p_usr) else $error("user map lost");
   property p_enc; o_submap_select != 2'h0 |-> !o_sel_user; endproperty
   a_enc: assert property (p_enc) else $error("bad select code");
   property p_main; o_hit_main |-> $past(i_addr_valid) && $past(i_addr_byte[7:2]) == 6'h10; endproperty
   a_main: assert property (p_main) else $error("bad main hit");
   property p_ack; o_addr_ack == (o_hit_main || o_hit_out_map); endproperty
   a_ack: assert property (p_ack) else $error("ack mismatch");
   property p_rd; o_hit_out_map |-> o_read_xfer == $past(i_addr_byte[0]); endproperty
   a_rd: assert property (p_rd) else $error("read bit lost");
   property p_off; o_hit_out_map |-> $past(i_addr_byte[7:1]) != 7'h00; endproperty
   a_off: assert property (p_off) else $error("map hit at zero");
endmodule
bind masel_top masel_chk masel_chk_i (.*);
`default_nettype wire

// *** testbench/masel_host.sv ***
// host model: decoded i2c transfers, released lines show inverse data
// assumes the caller enters each task at a falling edge
`timescale 1ns/100ps
`default_nettype none
module masel_host (
   input  wire logic       i_clk,
   output var  logic       o_av,
   output var  logic [7:0] o_ab,
   output var  logic       o_we,
   output var  logic       o_re,
   output var  logic [7:0] o_ra,
   output var  logic [7:0] o_wd
);
   initial {o_av, o_ab, o_we, o_re, o_ra, o_wd} = 27'h0;
   // each task waits for the next falling edge and drives on it, so two calls in a row
   // never change a line twice in one time step
   task xfer(input logic [7:0] b);
      @(negedge i_clk) {o_av, o_ab} = {1'b1, b};
      @(negedge i_clk) {o_av, o_ab} = {1'b0, ~b};
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk) {o_we, o_ra, o_wd} = {1'b1, a, d};
      @(negedge i_clk) {o_we, o_ra, o_wd} = {1'b0, ~a, ~d};
   endtask
   task rd(input logic [7:0] a);
      @(negedge i_clk) {o_re, o_ra} = {1'b1, a};
      @(negedge i_clk) {o_re, o_ra} = {1'b0, ~a};
   endtask
endmodule
`default_nettype wire

// *** testbench/tb_masel_top.sv ***
// bench for masel_top, scenarios judged at the falling edge
// assumes masel_host drives the decoded bus
`timescale 1ns/100ps
`default_nettype none
module tb_masel_top;
   logic i_sys_clk = 0, i_rst_b = 0, i_address_strap_input = 0;
   logic i_addr_valid, i_reg_we, i_reg_re, o_addr_ack, o_hit_main, o_hit_out_map, o_read_xfer;
   logic o_sel_user, o_sel_intr_vbi, o_sel_user2, o_reg_hit;
   logic [7:0] i_addr_byte, i_reg_addr, i_reg_wdata, o_reg_rdata;
   logic [1:0] o_submap_select;
   int failures = 0, n_tests = 0;
   always #20 i_sys_clk = ~i_sys_clk;
   masel_top masel_top_i (.*);
   masel_host masel_host_i (.i_clk(i_sys_clk), .o_av(i_addr_valid), .o_ab(i_addr_byte),
      .o_we(i_reg_we), .o_re(i_reg_re), .o_ra(i_reg_addr), .o_wd(i_reg_wdata));
   ////////////////////////////////////////////////////////////
   task chk(input logic [7:0] g, input logic [7:0] e);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("mismatch t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // e = {ack, main, out map, read}
   task addr(input logic [7:0] b, input logic [3:0] e);
      masel_host_i.xfer(b);
      chk({4'h0, o_addr_ack, o_hit_main, o_hit_out_map, o_read_xfer}, {4'h0, e});
   endtask
   task stop_test;
      $display("failures %0d tests %0d", failures, n_tests);
      if (failures == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task t_reset;
      chk({5'h0, o_submap_select, o_sel_user}, 8'h01);
      masel_host_i.rd(8'hfe);
      chk({o_reg_hit, 7'h0} | o_reg_rdata, 8'h80);
      addr(8'h89, 4'h1);
   endtask
   task t_main;
      addr(8'h40, 4'hc);
      addr(8'h41, 4'hd);
      addr(8'h42, 4'h0);
      i_address_strap_input = 1;
      repeat (3) @(negedge i_sys_clk);
      addr(8'h43, 4'hd);
      addr(8'h40, 4'h0);
   endtask
   task t_map;
      masel_host_i.wr(8'hfe, 8'h88);
      masel_host_i.rd(8'hfe);
      chk(o_reg_rdata, 8'h88);
      addr(8'h89, 4'hb);
      addr(8'h88, 4'ha);
   endtask
   // codes 1, 2, 3, then 0 to return; 0xfe must be ignored away from the user map
   task t_sel;
      for (int k = 1; k < 5; k++) begin
         masel_host_i.wr(8'h0e, {1'b0, k[1:0], 5'h00});
         @(negedge i_sys_clk);
         chk({3'h0, o_submap_select, o_sel_user, o_sel_intr_vbi, o_sel_user2},
            {3'h0, k[1:0], k[1:0] == 2'h0, k[1:0] == 2'h1, k[1:0] == 2'h2});
         if (k == 1) begin
            masel_host_i.wr(8'hfe, 8'h00);
            masel_host_i.rd(8'hfe);
            chk({o_reg_hit, 7'h0} | o_reg_rdata, 8'h00);
            masel_host_i.rd(8'h0e);
            chk(o_reg_rdata, 8'h20);
         end
      end
      addr(8'h89, 4'hb);
   endtask
   initial begin
      repeat (20) @(negedge i_sys_clk);
      i_rst_b = 1;
      @(negedge i_sys_clk);
      t_reset;
      t_main;
      t_map;
      t_sel;
      i_rst_b = 0;
      @(negedge i_sys_clk) i_rst_b = 1;
      @(negedge i_sys_clk);
      t_reset;
      stop_test;
   end
endmodule
`default_nettype wire
